// >>> shared/spdg_pkg.sv
// Constants and types for the signal path and digital gain block.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
package spdg_pkg;
    localparam int MOD_W = 32;
    localparam int CONV_W = 24;
    localparam int GAIN_W = 3;
    localparam int PATH_W = 2;
    localparam logic [1:0] PATH_BYPASS = 2'h0;
    localparam logic [1:0] PATH_BUFFER = 2'h1;
    localparam logic [1:0] PATH_AMP = 2'h2;
    // Low bit index of the kept slice for each digital gain
    localparam int LSB_X1 = 8;
    localparam int LSB_X2 = 7;
    localparam int LSB_X4 = 6;
    localparam logic [2:0] GAIN_CODE_X2 = 3'h1;
    localparam logic [2:0] GAIN_CODE_X4 = 3'h2;
    localparam logic [2:0] RST_GAIN = 3'h0;
    localparam logic [1:0] RST_PATH = 2'h0;
    // Reset leaves the lowest-power direct path selected
    localparam logic RST_DIRECT = 1'b1;
    localparam logic RST_BUF = 1'b0;
    localparam logic RST_AMP = 1'b0;
    localparam logic RST_VALID = 1'b0;
    localparam logic [23:0] RST_CONV = 24'h000000;
    typedef enum logic [1:0] {SPDG_DG_X1, SPDG_DG_X2, SPDG_DG_X4} spdg_dgain_e;
endpackage : spdg_pkg

// >>> src/spdg_slicer.sv
// Bit-slice selector turning a modulator word into a conversion word.
// Assumes the gain selection is already clamped to x1, x2 or x4.
`timescale 1ns/100ps
module spdg_slicer (
    // Input word and gain
    input wire logic [31:0] mod_word,
    input wire logic [1:0] dgain,
    // Output
    output logic [23:0] conv_word
);
    wire logic [23:0] slice_x1 = mod_word[spdg_pkg::LSB_X1 +: 24];
    wire logic [23:0] slice_x2 = mod_word[spdg_pkg::LSB_X2 +: 24];
    wire logic [23:0] slice_x4 = mod_word[spdg_pkg::LSB_X4 +: 24];
    assign conv_word = (dgain == 2'(spdg_pkg::SPDG_DG_X4)) ? slice_x4 :
                       (dgain == 2'(spdg_pkg::SPDG_DG_X2)) ? slice_x2 :
                       slice_x1;
endmodule : spdg_slicer

// >>> src/spdg_top.sv
// Signal path selection and digital gain scaling for the converter front end.
// Assumes path and gain come from a register file elsewhere, on clk.
`timescale 1ns/100ps
module spdg_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] path_sel,
    input wire logic [2:0] gain_sel,
    // Modulator result
    input wire logic [31:0] mod_data,
    input wire logic mod_valid,
    // Analog enables
    output logic buf_en,
    output logic amp_en,
    output logic direct_en,
    output logic [2:0] amp_gain,
    // Conversion result
    output logic [23:0] conv_data,
    output logic conv_valid
);
    logic [1:0] path_reg;
    logic [2:0] gain_reg;
    logic buf_en_reg, amp_en_reg, direct_en_reg;
    logic [2:0] amp_gain_reg;
    logic [23:0] conv_reg;
    logic valid_reg;

    // Path decoding is shared by the live and the registered selection
    function automatic logic path_is_amp(logic [1:0] p);
        return p == spdg_pkg::PATH_AMP;
    endfunction : path_is_amp

    function automatic logic path_is_buf(logic [1:0] p);
        return p == spdg_pkg::PATH_BUFFER;
    endfunction : path_is_buf

    // Reserved path code 3 falls back to bypass, the lowest-power choice
    wire logic is_amp = path_is_amp(path_sel);
    wire logic is_buf = path_is_buf(path_sel);
    wire logic is_dir = !is_amp && !is_buf;
    wire logic buf_en_next = is_buf;
    wire logic amp_en_next = is_amp;
    wire logic direct_en_next = is_dir;
    // Analog gain 2**code applies only while the amplifier is in the path
    wire logic [2:0] amp_gain_next = is_amp ? gain_sel : spdg_pkg::RST_GAIN;

    // Digital gain follows the path held in registers, so the slice never
    // changes mid-word relative to the path that produced it
    wire logic [1:0] dgain_sel;
    assign dgain_sel = path_is_amp(path_reg) ? 2'(spdg_pkg::SPDG_DG_X1) :
        (gain_reg >= spdg_pkg::GAIN_CODE_X4) ? 2'(spdg_pkg::SPDG_DG_X4) :
        (gain_reg == spdg_pkg::GAIN_CODE_X2) ? 2'(spdg_pkg::SPDG_DG_X2) :
        2'(spdg_pkg::SPDG_DG_X1);
    wire logic [23:0] conv_next;

    spdg_slicer u_slicer (
        .mod_word(mod_data),
        .dgain(dgain_sel),
        .conv_word(conv_next)
    );

    // Configuration copy that steers the slice for the next word
    always_ff @(posedge clk) begin
        if (rst) begin
            path_reg <= spdg_pkg::RST_PATH;
            gain_reg <= spdg_pkg::RST_GAIN;
        end else begin
            path_reg <= path_sel;
            gain_reg <= gain_sel;
        end
    end

    // Analog enables, registered so the pins never glitch on decode
    always_ff @(posedge clk) begin
        if (rst) begin
            buf_en_reg <= spdg_pkg::RST_BUF;
            amp_en_reg <= spdg_pkg::RST_AMP;
            direct_en_reg <= spdg_pkg::RST_DIRECT;
            amp_gain_reg <= spdg_pkg::RST_GAIN;
        end else begin
            buf_en_reg <= buf_en_next;
            amp_en_reg <= amp_en_next;
            direct_en_reg <= direct_en_next;
            amp_gain_reg <= amp_gain_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_reg <= spdg_pkg::RST_CONV;
            valid_reg <= spdg_pkg::RST_VALID;
        end else begin
            valid_reg <= mod_valid;
            if (mod_valid) begin
                conv_reg <= conv_next;
            end
        end
    end

    assign buf_en = buf_en_reg;
    assign amp_en = amp_en_reg;
    assign direct_en = direct_en_reg;
    assign amp_gain = amp_gain_reg;
    assign conv_data = conv_reg;
    assign conv_valid = valid_reg;

    wire logic path_amp_q = path_is_amp(path_reg);
    wire logic path_buf_q = path_is_buf(path_reg);

    sequence s_cfg_amp;
        !rst && path_sel == spdg_pkg::PATH_AMP;
    endsequence
    sequence s_amp_on;
        amp_en && !buf_en && !direct_en;
    endsequence

    sequence s_cfg_buf;
        !rst && path_sel == spdg_pkg::PATH_BUFFER;
    endsequence

    sequence s_buf_on;
        buf_en && !amp_en && !direct_en;
    endsequence

    sequence s_word_amp;
        mod_valid && path_amp_q;
    endsequence

    // Codes four to seven all clamp to the x4 slice
    sequence s_word_clamp;
        mod_valid && !path_amp_q && gain_reg[2];
    endsequence

    AST_BUF_PATH: assert property (@(posedge clk) disable iff (rst)
        path_sel == spdg_pkg::PATH_BUFFER |=> buf_en && !amp_en && !direct_en)
        else $error("buffered path enables wrong");
    AST_AMP_PATH: assert property (@(posedge clk) disable iff (rst)
        s_cfg_amp |=> s_amp_on)
        else $error("amplifier path enables wrong");
    AST_AMP_GAIN: assert property (@(posedge clk) disable iff (rst)
        s_cfg_amp |=> amp_gain == $past(gain_sel))
        else $error("amplifier gain not applied");
    AST_BYP_PATH: assert property (@(posedge clk) disable iff (rst)
        path_sel == spdg_pkg::PATH_BYPASS |=> direct_en && !buf_en && !amp_en)
        else $error("bypass path enables wrong");
    AST_DG_X1: assert property (@(posedge clk) disable iff (rst)
        mod_valid && (path_amp_q || gain_reg == 3'h0)
        |=> conv_data == $past(mod_data[31:8]))
        else $error("unity slice wrong");
    AST_DG_X2: assert property (@(posedge clk) disable iff (rst)
        mod_valid && !path_amp_q && gain_reg == spdg_pkg::GAIN_CODE_X2
        |=> conv_data == $past(mod_data[30:7]))
        else $error("gain two slice wrong");
    AST_DG_X4: assert property (@(posedge clk) disable iff (rst)
        mod_valid && !path_amp_q && gain_reg >= spdg_pkg::GAIN_CODE_X4
        |=> conv_data == $past(mod_data[29:6]))
        else $error("gain four slice wrong");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        !mod_valid |=> $stable(conv_data) && !conv_valid)
        else $error("result changed without valid");
    AST_BUF_NOAMP: assert property (@(posedge clk) disable iff (rst)
        path_buf_q |-> !amp_en)
        else $error("amplifier on in buffered path");

    AST_RST_STATE: assert property (@(posedge clk)
        rst |=> direct_en && !buf_en && !amp_en && amp_gain == 3'h0
        && !conv_valid && conv_data == 24'h000000)
        else $error("reset state wrong");

    AST_ONE_PATH: assert property (@(posedge clk) disable iff (rst)
        $onehot({buf_en, amp_en, direct_en}))
        else $error("more than one signal path enabled");

    AST_RSV_BYP: assert property (@(posedge clk) disable iff (rst)
        path_sel[1] && path_sel[0] |=> direct_en && !buf_en && !amp_en)
        else $error("reserved path code not bypass");

    AST_GAIN_IDLE: assert property (@(posedge clk) disable iff (rst)
        path_sel != spdg_pkg::PATH_AMP |=> amp_gain == 3'h0)
        else $error("analog gain set outside amplifier path");

    AST_AMP_UNITY: assert property (@(posedge clk) disable iff (rst)
        s_word_amp |=> conv_data == $past(mod_data[31:8]))
        else $error("amplifier path slice not unity");

    AST_DIG_CLAMP: assert property (@(posedge clk) disable iff (rst)
        s_word_clamp |=> conv_data == $past(mod_data[29:6]))
        else $error("high gain code not clamped to four");

    AST_VALID_FOLLOW: assert property (@(posedge clk) disable iff (rst)
        mod_valid |=> conv_valid)
        else $error("result valid missing");

    AST_BUF_STEADY: assert property (@(posedge clk) disable iff (rst)
        s_cfg_buf ##1 s_cfg_buf |=> s_buf_on)
        else $error("buffered path not held");

    AST_AMP_STEADY: assert property (@(posedge clk) disable iff (rst)
        s_cfg_amp ##1 s_cfg_amp |=> s_amp_on)
        else $error("amplifier path not held");

    AST_AMP_NOBUF: assert property (@(posedge clk) disable iff (rst)
        path_amp_q |-> !buf_en && !direct_en)
        else $error("buffers on in amplifier path");

    AST_DIR_NOAMP: assert property (@(posedge clk) disable iff (rst)
        !path_amp_q && !path_buf_q |-> direct_en && !amp_en && !buf_en)
        else $error("bypass path enables wrong");

    // Two idle cycles in a row must leave the stored word untouched
    AST_DATA_HOLD: assert property (@(posedge clk) disable iff (rst)
        !mod_valid ##1 !mod_valid |=> $stable(conv_data))
        else $error("result drifted while idle");
endmodule : spdg_top

// >>> verif/spdg_top_bench.sv
// Self-checking bench for the signal path and digital gain block.
// Drives every port itself; inputs change on the falling edge of clk.
`timescale 1ns/100ps
module spdg_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] path_sel = 2'h0;
    logic [2:0] gain_sel = 3'h0;
    logic [31:0] mod_data = 32'h0;
    logic mod_valid = 1'b0;
    logic buf_en, amp_en, direct_en, conv_valid;
    logic [2:0] amp_gain;
    logic [23:0] conv_data;
    logic [31:0] corner [4] = '{32'h80000000, 32'h7fffffff, 32'hc0000180,
                                32'h3fffffc0};
    int fails = 0;
    int n_tests = 0;
    int seed = 87;
    always #50 clk = ~clk;
    spdg_top dut (.clk(clk), .rst(rst), .path_sel(path_sel),
        .gain_sel(gain_sel), .mod_data(mod_data), .mod_valid(mod_valid),
        .buf_en(buf_en), .amp_en(amp_en), .direct_en(direct_en),
        .amp_gain(amp_gain), .conv_data(conv_data), .conv_valid(conv_valid));
    // Amplifier path keeps the word at unity; codes 2..7 clamp to x4
    function automatic logic [23:0] exp_conv(logic [1:0] p, logic [2:0] g,
                                             logic [31:0] w);
        if (p == spdg_pkg::PATH_AMP || g == 3'h0) return w[31:8];
        if (g == 3'h1) return w[30:7];
        return w[29:6];
    endfunction : exp_conv
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // Word is sent one cycle after config so the slice sees settled gain
    task automatic run(logic [1:0] p, logic [2:0] g, logic [31:0] w);
        path_sel = p;
        gain_sel = g;
        @(negedge clk);
        mod_data = w;
        mod_valid = 1'b1;
        @(negedge clk);
        mod_valid = 1'b0;
        check("buf_en", 32'(p == spdg_pkg::PATH_BUFFER), buf_en);
        check("amp_en", 32'(p == spdg_pkg::PATH_AMP), amp_en);
        check("direct_en", 32'(p[1] == p[0]), direct_en);
        check("amp_gain", p == spdg_pkg::PATH_AMP ? g : 3'h0, amp_gain);
        check("conv_valid", 32'h1, conv_valid);
        check("conv_data", exp_conv(p, g, w), conv_data);
        @(negedge clk);
        check("conv_valid_drop", 32'h0, conv_valid);
        check("conv_hold", exp_conv(p, g, w), conv_data);
    endtask : run
    initial begin
        repeat (4) @(negedge clk);
        check("rst_direct", 32'h1, direct_en);
        check("rst_buf", 32'h0, buf_en);
        check("rst_amp", 32'h0, amp_en);
        check("rst_conv", 32'h0, {conv_valid, conv_data});
        rst = 1'b0;
        $display("Test reset done");
        // Every path and gain code, random words then edge patterns
        for (int i = 0; i < 64; i++) begin
            run(i[4:3], i[2:0], i < 32 ? $random(seed) : corner[i % 4]);
        end
        $display("Test sweep done");
        // Back-to-back words at gain two on the buffered path
        path_sel = spdg_pkg::PATH_BUFFER;
        gain_sel = spdg_pkg::GAIN_CODE_X2;
        @(negedge clk);
        mod_valid = 1'b1;
        mod_data = corner[2];
        @(negedge clk);
        mod_data = corner[3];
        check("b2b_first", exp_conv(2'h1, 3'h1, corner[2]), conv_data);
        @(negedge clk);
        mod_valid = 1'b0;
        check("b2b_second", exp_conv(2'h1, 3'h1, corner[3]), conv_data);
        check("b2b_valid", 32'h1, conv_valid);
        $display("Test back_to_back done");
        // Reset in mid-run returns to the direct path and clears the word
        rst = 1'b1;
        @(negedge clk);
        check("mid_rst_en", 32'h4, {direct_en, buf_en, amp_en});
        check("mid_rst_conv", 32'h0, {conv_valid, conv_data});
        rst = 1'b0;
        $display("Test mid_reset done");
        end_of_test();
    end
endmodule : spdg_top_bench
